// [hw/bic_channel.sv]
// buffered character channel with single-word and interlace modes
// How it works
// - control instruction loads and shows unit address
// - control instruction loads characters-per-word count
// - control instruction clears full, error; starts unit
// - leading address bit selects input or output
// - zero unit address means ready and disconnected
// - parity failure sets error flag for testing
// - input character goes to low six bits
// - input: decrement count, shift left six
// - end of record pads word with zeros
// - full word sets full; end-of-word, memory write or end
// - end of transmission clears address, raises irq
// - buffer-to-memory read clears full flag
// - memory-to-buffer write sets full, starts output
// - output sends top six bits as character
// - output: decrement count, shift left six
// - exhausted output word: terminate or request more
// - interlace start loads word count and address
// - interlace moves words to or from memory
// - each interlaced word bumps address, drops count
// - interlace end of record ends transfer
// - interlaced output count exhausted ends transfer
// - interlaced input count exhausted reverts to single-word
// - end irq reaches program only when enabled
module bic_channel (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       srst,
   // processor instruction port
   input  wire logic                       ctl_strobe,
   input  wire logic [bic_pkg::WORD_W-1:0] ctl_word,
   input  wire logic                       ctl_interlace,
   input  wire logic [bic_pkg::ADDR_W-1:0] ctl_word_count,
   input  wire logic [bic_pkg::ADDR_W-1:0] ctl_start_addr,
   input  wire logic                       buf_to_mem_strobe,
   output logic      [bic_pkg::WORD_W-1:0] buf_to_mem_data,
   input  wire logic                       mem_to_buf_strobe,
   input  wire logic [bic_pkg::WORD_W-1:0] mem_to_buf_data,
   input  wire logic                       terminate_strobe,
   input  wire logic                       irq_enable,
   // status
   output logic      [bic_pkg::UA_W-1:0]   unit_address_display,
   output logic                            channel_ready_test,
   output logic                            channel_error_test,
   output logic                            buffer_full_flag,
   output logic                            end_of_word_irq,
   output logic                            end_of_transmission_irq,
   output logic                            program_irq,
   // peripheral pins
   output logic                            dev_start,
   output logic      [bic_pkg::UA_W-1:0]   dev_unit,
   input  wire logic                       dev_char_valid,
   input  wire logic [bic_pkg::CHAR_W-1:0] dev_char,
   input  wire logic                       dev_char_parity,
   input  wire logic                       dev_end_of_record,
   output logic                            dev_out_valid,
   output logic      [bic_pkg::CHAR_W-1:0] dev_out_char,
   output logic                            dev_out_parity,
   input  wire logic                       dev_out_ack,
   // interlace memory port
   output logic                            mem_req,
   output logic                            mem_we,
   output logic      [bic_pkg::ADDR_W-1:0] mem_addr,
   output logic      [bic_pkg::WORD_W-1:0] mem_wdata,
   input  wire logic [bic_pkg::WORD_W-1:0] mem_rdata
);
   import bic_pkg::*;

   // odd parity over a character with its parity bit
   function automatic logic par_ok(input logic [CHAR_W-1:0] c, input logic p);
      par_ok = ^{c, p};
   endfunction : par_ok

   bic_state_t              state_ff, nxt_state;
   logic [UA_W-1:0]         unit_address_register_ff, nxt_uar;
   logic [CNT_W-1:0]        char_per_word_ff, nxt_cpw;
   logic [CNT_W-1:0]        character_count_ff, nxt_cc;
   logic [WORD_W-1:0]       word_assembly_register_ff, nxt_war;
   logic [CHAR_W-1:0]       single_character_register_ff, nxt_scr;
   logic                    full_ff, nxt_full;
   logic                    err_ff, nxt_err;
   logic                    eor_seen_ff, nxt_eor;
   logic                    term_ff, nxt_term;
   logic                    ilace_ff, nxt_ilace;
   logic [ADDR_W-1:0]       word_count_register_ff, nxt_wcr;
   logic [ADDR_W-1:0]       transfer_address_register_ff, nxt_tar;
   logic                    eow_ff, nxt_eow;
   logic                    eot_ff, nxt_eot;
   logic                    send_ff, nxt_send;
   logic                    start_ff, nxt_start;
   // pin inputs synchronised
   logic                    cv_s1, cv_s2, eor_s1, eor_s2, ack_s1, ack_s2;
   logic [CHAR_W-1:0]       ch_s1, ch_s2;
   logic                    par_s1, par_s2;

   wire is_output  = unit_address_register_ff[UA_W-1];
   wire connected  = (unit_address_register_ff != UA_IDLE);
   wire cc_done    = (character_count_ff == CC_ZERO);
   wire wc_last    = (word_count_register_ff == WC_ONE);
   // count already dropped in the memory cycle, so the end of output is zero
   wire wc_zero    = (word_count_register_ff == WC_ZERO);
   wire [UA_W-1:0]  ins_ua  = ctl_word[WORD_W-1-UA_LSB +: UA_W];  // bits 18..23, bit 0 is msb
   wire [CNT_W-1:0] ins_cc  = ctl_word[WORD_W-1-CC_LSB +: CNT_W];
   wire [WORD_W-1:0] war_shift = {word_assembly_register_ff[WORD_W-CHAR_W-1:0], {CHAR_W{1'b0}}};

   always_ff @(posedge sys_clk) begin
      cv_s1  <= dev_char_valid;
      cv_s2  <= cv_s1;
      ch_s1  <= dev_char;
      ch_s2  <= ch_s1;
      par_s1 <= dev_char_parity;
      par_s2 <= par_s1;
      eor_s1 <= dev_end_of_record;
      eor_s2 <= eor_s1;
      ack_s1 <= dev_out_ack;
      ack_s2 <= ack_s1;
   end

   // one character per cycle of valid: peripheral drops valid between characters
   logic cv_d_ff, ack_d_ff;
   always_ff @(posedge sys_clk) begin
      cv_d_ff  <= srst ? 1'b0 : cv_s2;
      ack_d_ff <= srst ? 1'b0 : ack_s2;
   end
   wire char_in  = cv_s2 & ~cv_d_ff;
   wire char_ack = ack_s2 & ~ack_d_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_uar   = unit_address_register_ff;
      nxt_cpw   = char_per_word_ff;
      nxt_cc    = character_count_ff;
      nxt_war   = word_assembly_register_ff;
      nxt_scr   = single_character_register_ff;
      nxt_full  = full_ff;
      nxt_err   = err_ff;
      nxt_eor   = eor_seen_ff;
      nxt_term  = term_ff | terminate_strobe;
      nxt_ilace = ilace_ff;
      nxt_wcr   = word_count_register_ff;
      nxt_tar   = transfer_address_register_ff;
      nxt_eow   = 1'b0;
      nxt_eot   = 1'b0;
      nxt_send  = send_ff;
      nxt_start = 1'b0;
      if (ctl_strobe) begin
         nxt_uar   = ins_ua;
         nxt_cpw   = ins_cc;
         nxt_cc    = ins_cc;
         nxt_full  = 1'b0;
         nxt_err   = 1'b0;
         nxt_start = 1'b1;
         // single-word output asks for its first word at once
         nxt_eow   = ins_ua[UA_W-1] & ~ctl_interlace;
         nxt_eor   = 1'b0;
         nxt_term  = 1'b0;
         nxt_war   = WORD_ZERO;
         nxt_ilace = ctl_interlace;
         nxt_wcr   = ctl_word_count;
         nxt_tar   = ctl_start_addr;
         nxt_state = ins_ua[UA_W-1] ? (ctl_interlace ? BIC_MEM : BIC_WAIT) : BIC_GET;
         if (ins_ua == UA_IDLE) nxt_state = BIC_IDLE;
      end else begin
         case (state_ff)
            BIC_IDLE: begin
            end
            BIC_GET: begin
               if (char_in) begin
                  if (!par_ok(ch_s2, par_s2)) nxt_err = 1'b1;
                  nxt_war = {word_assembly_register_ff[WORD_W-1:CHAR_W], ch_s2};
                  nxt_eor = eor_seen_ff | eor_s2;
                  nxt_state = BIC_FILL;
               end else if (eor_s2) begin
                  nxt_eor = 1'b1;
                  nxt_state = BIC_FILL;
               end
            end
            BIC_FILL: begin
               if (cc_done) begin
                  nxt_full = 1'b1;
                  if (eor_seen_ff) begin
                     nxt_uar = UA_IDLE;
                     nxt_eot = 1'b1;
                     nxt_ilace = 1'b0;
                     nxt_state = BIC_IDLE;
                  end else if (ilace_ff) begin
                     nxt_state = BIC_MEM;
                  end else begin
                     nxt_eow = 1'b1;
                     nxt_state = BIC_WAIT;
                  end
               end else begin
                  nxt_cc  = character_count_ff - CC_ONE;
                  nxt_war = war_shift;
                  if (!eor_seen_ff) nxt_state = BIC_GET;
               end
            end
            BIC_MEM: begin
               nxt_tar = transfer_address_register_ff + ADDR_ONE;
               nxt_wcr = word_count_register_ff - WC_ONE;
               nxt_cc  = char_per_word_ff;
               if (is_output) begin
                  nxt_war  = mem_rdata;
                  nxt_full = 1'b1;
                  nxt_state = BIC_SEND;
               end else begin
                  nxt_full = 1'b0;
                  nxt_war  = WORD_ZERO;
                  if (wc_last) nxt_ilace = 1'b0;
                  nxt_state = BIC_GET;
               end
            end
            BIC_WAIT: begin
               if (!is_output && buf_to_mem_strobe) begin
                  nxt_full = 1'b0;
                  nxt_cc   = char_per_word_ff;
                  nxt_war  = WORD_ZERO;
                  nxt_state = BIC_GET;
               end else if (is_output && mem_to_buf_strobe) begin
                  nxt_full = 1'b1;
                  nxt_war  = mem_to_buf_data;
                  nxt_cc   = char_per_word_ff;
                  nxt_state = BIC_SEND;
               end else if (is_output && term_ff) begin
                  nxt_uar = UA_IDLE;
                  nxt_eot = 1'b1;
                  nxt_state = BIC_IDLE;
               end
            end
            BIC_SEND: begin
               if (!send_ff) begin
                  nxt_scr  = word_assembly_register_ff[WORD_W-1 -: CHAR_W];
                  nxt_send = 1'b1;
               end else if (char_ack) begin
                  nxt_send = 1'b0;
                  if (!par_ok(single_character_register_ff, dev_out_parity)) nxt_err = 1'b1;
                  if (!cc_done) begin
                     nxt_cc  = character_count_ff - CC_ONE;
                     nxt_war = war_shift;
                  end else begin
                     nxt_full = 1'b0;
                     if (term_ff || (ilace_ff && wc_zero) || (ilace_ff && eor_s2)) begin
                        nxt_uar = UA_IDLE;
                        nxt_eot = 1'b1;
                        nxt_ilace = 1'b0;
                        nxt_state = BIC_IDLE;
                     end else if (ilace_ff) begin
                        nxt_state = BIC_MEM;
                     end else begin
                        nxt_eow = 1'b1;
                        nxt_state = BIC_WAIT;
                     end
                  end
               end
            end
            default: nxt_state = BIC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff                     <= BIC_IDLE;
         unit_address_register_ff     <= UA_IDLE;
         char_per_word_ff             <= CC_ZERO;
         character_count_ff           <= CC_ZERO;
         word_assembly_register_ff    <= WORD_ZERO;
         single_character_register_ff <= '0;
         full_ff                      <= 1'b0;
         err_ff                       <= 1'b0;
         eor_seen_ff                  <= 1'b0;
         term_ff                      <= 1'b0;
         ilace_ff                     <= 1'b0;
         word_count_register_ff       <= WC_ZERO;
         transfer_address_register_ff <= '0;
         eow_ff                       <= 1'b0;
         eot_ff                       <= 1'b0;
         send_ff                      <= 1'b0;
         start_ff                     <= 1'b0;
      end else begin
         state_ff                     <= nxt_state;
         unit_address_register_ff     <= nxt_uar;
         char_per_word_ff             <= nxt_cpw;
         character_count_ff           <= nxt_cc;
         word_assembly_register_ff    <= nxt_war;
         single_character_register_ff <= nxt_scr;
         full_ff                      <= nxt_full;
         err_ff                       <= nxt_err;
         eor_seen_ff                  <= nxt_eor;
         term_ff                      <= nxt_term;
         ilace_ff                     <= nxt_ilace;
         word_count_register_ff       <= nxt_wcr;
         transfer_address_register_ff <= nxt_tar;
         eow_ff                       <= nxt_eow;
         eot_ff                       <= nxt_eot;
         send_ff                      <= nxt_send;
         start_ff                     <= nxt_start;
      end
   end

   assign unit_address_display    = unit_address_register_ff;
   assign channel_ready_test      = ~connected;
   assign channel_error_test      = err_ff;
   assign buffer_full_flag        = full_ff;
   assign end_of_word_irq         = eow_ff;
   assign end_of_transmission_irq = eot_ff;
   assign program_irq             = eot_ff & irq_enable;
   assign buf_to_mem_data         = word_assembly_register_ff;
   assign dev_start               = start_ff;
   assign dev_unit                = unit_address_register_ff;
   assign dev_out_valid           = send_ff;
   assign dev_out_char            = single_character_register_ff;
   // odd parity generated on the character sent
   assign dev_out_parity          = ~^single_character_register_ff;
   assign mem_req                 = (state_ff == BIC_MEM);
   assign mem_we                  = (state_ff == BIC_MEM) & ~is_output;
   assign mem_addr                = transfer_address_register_ff;
   assign mem_wdata               = word_assembly_register_ff;

   AST_CTL_LOAD: assert property (@(posedge sys_clk) disable iff (srst)
      ctl_strobe |=> unit_address_display == $past(ins_ua) && !buffer_full_flag && !channel_error_test)
      else $error("control load wrong");
   AST_READY: assert property (@(posedge sys_clk) disable iff (srst)
      (unit_address_register_ff == UA_IDLE) |-> channel_ready_test)
      else $error("ready wrong");
   AST_EOT_CLR: assert property (@(posedge sys_clk) disable iff (srst)
      end_of_transmission_irq |-> unit_address_display == UA_IDLE)
      else $error("eot without disconnect");
   AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (srst)
      program_irq |-> irq_enable && end_of_transmission_irq)
      else $error("irq not gated");
   AST_EOW_FULL: assert property (@(posedge sys_clk) disable iff (srst)
      (end_of_word_irq && !is_output) |-> buffer_full_flag)
      else $error("eow without full");
   AST_WIM_CLR: assert property (@(posedge sys_clk) disable iff (srst)
      (state_ff == BIC_WAIT && !is_output && buf_to_mem_strobe && !ctl_strobe) |=> !buffer_full_flag)
      else $error("full not cleared");
   AST_MIW_SET: assert property (@(posedge sys_clk) disable iff (srst)
      (state_ff == BIC_WAIT && is_output && mem_to_buf_strobe && !ctl_strobe) |=> buffer_full_flag ##1 dev_out_valid)
      else $error("output not started");
   AST_NEXT: assert property (@(posedge sys_clk) disable iff (srst)
      (mem_req && !ctl_strobe) |=> mem_addr == $past(mem_addr) + ADDR_ONE)
      else $error("address not bumped");
   AST_SEND_CHAR: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(dev_out_valid) |-> dev_out_char == word_assembly_register_ff[WORD_W-1 -: CHAR_W])
      else $error("wrong character");
   COV_EOW: cover property (@(posedge sys_clk) disable iff (srst) end_of_word_irq);
   COV_EOT: cover property (@(posedge sys_clk) disable iff (srst) end_of_transmission_irq);
   COV_ILACE: cover property (@(posedge sys_clk) disable iff (srst) mem_req && mem_we);
endmodule : bic_channel

// [hw/bic_pkg.sv]
// constants and types for the buffered io channel
package bic_pkg;
   localparam int WORD_W     = 24;
   localparam int CHAR_W     = 6;
   localparam int UA_W       = 6;
   localparam int CNT_W      = 2;
   localparam int ADDR_W     = 14;
   localparam int UA_MSB     = 18;
   localparam int UA_LSB     = 23;
   localparam int CC_MSB     = 15;
   localparam int CC_LSB     = 16;
   localparam int DIR_BIT    = 18;
   localparam logic [UA_W-1:0]   UA_IDLE  = 6'h00;
   localparam logic [CNT_W-1:0]  CC_ZERO  = 2'h0;
   localparam logic [CNT_W-1:0]  CC_ONE   = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
   localparam logic [ADDR_W-1:0] WC_ZERO  = 14'h0000;
   localparam logic [ADDR_W-1:0] WC_ONE   = 14'h0001;
   localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

   typedef enum logic [5:0] {
      BIC_IDLE = 6'b000001,
      BIC_GET  = 6'b000010,
      BIC_SEND = 6'b000100,
      BIC_WAIT = 6'b001000,
      BIC_FILL = 6'b010000,
      BIC_MEM  = 6'b100000
   } bic_state_t;
endpackage : bic_pkg

// [sim/bic_dev_model.sv]
// partner model: character peripheral and word memory facing the channel
module bic_dev_model (
   // clock
   input  wire logic        sys_clk,
   // character input pins
   output logic             dev_char_valid,
   output logic [5:0]       dev_char,
   output logic             dev_char_parity,
   output logic             dev_end_of_record,
   // character output pins
   input  wire logic        dev_out_valid,
   input  wire logic [5:0]  dev_out_char,
   input  wire logic        dev_out_parity,
   output logic             dev_out_ack,
   // interlace memory
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [13:0] mem_addr,
   input  wire logic [23:0] mem_wdata,
   output logic      [23:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] mem [0:15];
   logic [5:0]  out_q [$];
   int          bad_par = 0;
   int          dly = 0;
   initial begin
      {dev_char_valid, dev_char, dev_char_parity, dev_end_of_record, dev_out_ack} = '0;
   end
   assign mem_rdata = mem[mem_addr[3:0]];
   always @(posedge sys_clk) begin
      if (mem_req === 1'b1 && mem_we === 1'b1) mem[mem_addr[3:0]] <= mem_wdata;
   end
   // ack held seven cycles so the channel's synchroniser is sure to see it
   always @(posedge sys_clk) begin
      dly <= dly + 1;
      if (dev_out_ack) begin
         if (dly == 6) begin
            dev_out_ack <= 1'b0;
            dly <= 0;
         end
      end else if (dev_out_valid !== 1'b1) dly <= 0;
      else if (dly == 3) begin
         out_q.push_back(dev_out_char);
         if (dev_out_parity !== ~^dev_out_char) bad_par++;
         dev_out_ack <= 1'b1;
         dly <= 0;
      end
   end
   task send_char(input logic [5:0] c, input logic bad, input logic eor);
      @(posedge sys_clk);
      dev_char <= c;
      dev_char_parity <= (~^c) ^ bad;
      @(posedge sys_clk);
      // end of record rides with the last character's valid edge
      dev_end_of_record <= eor;
      dev_char_valid <= 1'b1;
      repeat (6) @(posedge sys_clk);
      dev_char_valid <= 1'b0;
      // released data lines must not keep the last character
      dev_char <= ~c;
      repeat (6) @(posedge sys_clk);
   endtask : send_char
   task clr_eor;
      @(posedge sys_clk);
      dev_end_of_record <= 1'b0;
   endtask : clr_eor
endmodule : bic_dev_model

// [sim/tb_bic_channel.sv]
// self-checking bench for the buffered io channel
module tb_bic_channel;
   timeunit 1ns;
   timeprecision 1ps;
   import bic_pkg::*;
   logic              sys_clk = 1'b0;
   logic              srst, ctl_strobe, ctl_interlace, buf_to_mem_strobe, mem_to_buf_strobe, terminate_strobe;
   logic              irq_enable, channel_ready_test, channel_error_test, buffer_full_flag, end_of_word_irq;
   logic              end_of_transmission_irq, program_irq, dev_start, dev_char_valid, dev_char_parity;
   logic              dev_end_of_record, dev_out_valid, dev_out_parity, dev_out_ack, mem_req, mem_we, pirq;
   logic [WORD_W-1:0] ctl_word, buf_to_mem_data, mem_to_buf_data, mem_wdata, mem_rdata;
   logic [ADDR_W-1:0] ctl_word_count, ctl_start_addr, mem_addr;
   logic [UA_W-1:0]   unit_address_display, dev_unit, dev_char, dev_out_char;
   int                fail_count = 0, compares = 0, starts = 0, eows = 0, eots = 0, wrs = 0, e, t, s, w;

   bic_channel i_dut (.sys_clk, .srst, .ctl_strobe, .ctl_word, .ctl_interlace, .ctl_word_count,
      .ctl_start_addr, .buf_to_mem_strobe, .buf_to_mem_data, .mem_to_buf_strobe, .mem_to_buf_data,
      .terminate_strobe, .irq_enable, .unit_address_display, .channel_ready_test, .channel_error_test,
      .buffer_full_flag, .end_of_word_irq, .end_of_transmission_irq, .program_irq, .dev_start, .dev_unit,
      .dev_char_valid, .dev_char, .dev_char_parity, .dev_end_of_record, .dev_out_valid, .dev_out_char,
      .dev_out_parity, .dev_out_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
   bic_dev_model i_dev (.sys_clk, .dev_char_valid, .dev_char, .dev_char_parity, .dev_end_of_record,
      .dev_out_valid, .dev_out_char, .dev_out_parity, .dev_out_ack, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_rdata);

   always #5 sys_clk = ~sys_clk;
   // pulses are counted here so no scenario can miss a one-cycle event
   always @(posedge sys_clk) begin
      if (dev_start === 1'b1) starts++;
      if (end_of_word_irq === 1'b1) eows++;
      if (mem_req === 1'b1 && mem_we === 1'b1) wrs++;
      if (end_of_transmission_irq === 1'b1) begin
         eots++;
         pirq = program_irq;
      end
   end

   task chk(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task results;
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   task wait_cnt(input int sel, input int base);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(posedge sys_clk);
         #1;
         if ((sel == 0 ? eows : sel == 1 ? eots : sel == 2 ? wrs : sel == 3 ? i_dev.out_q.size() : starts) > base)
            return;
      end
      fail_count++;
      $display("wrong value wait %0d expected progress seen none", sel);
      results;
   endtask : wait_cnt
   task ctl(input logic [5:0] ua, input logic [1:0] cnt, input logic il, input logic [13:0] wc, sa);
      @(posedge sys_clk);
      ctl_strobe <= 1'b1;
      ctl_word <= {15'h0000, cnt, 1'b0, ua};
      ctl_interlace <= il;
      ctl_word_count <= wc;
      ctl_start_addr <= sa;
      @(posedge sys_clk);
      ctl_strobe <= 1'b0;
      #1;
   endtask : ctl
   task pulse(input int sel, input logic [WORD_W-1:0] d);
      @(posedge sys_clk);
      buf_to_mem_strobe <= (sel == 0);
      mem_to_buf_strobe <= (sel == 1);
      terminate_strobe <= (sel == 2);
      mem_to_buf_data <= d;
      @(posedge sys_clk);
      {buf_to_mem_strobe, mem_to_buf_strobe, terminate_strobe} <= 3'h0;
      #1;
   endtask : pulse

   task t_input;
      s = starts;
      e = eows;
      ctl(6'h11, 2'h3, 1'b0, 14'h0000, 14'h0000);
      chk("address", unit_address_display, 6'h11);
      chk("unit", dev_unit, 6'h11);
      chk("full", buffer_full_flag, 1'b0);
      chk("ready", channel_ready_test, 1'b0);
      wait_cnt(4, s);
      chk("starts", 24'(starts - s), 24'h000001);
      i_dev.send_char(6'h0a, 1'b0, 1'b0);
      i_dev.send_char(6'h15, 1'b0, 1'b0);
      i_dev.send_char(6'h2c, 1'b0, 1'b0);
      i_dev.send_char(6'h33, 1'b0, 1'b0);
      wait_cnt(0, e);
      chk("full", buffer_full_flag, 1'b1);
      chk("word", buf_to_mem_data, {6'h0a, 6'h15, 6'h2c, 6'h33});
      pulse(0, 24'h000000);
      chk("full", buffer_full_flag, 1'b0);
   endtask : t_input
   task t_parity;
      ctl(6'h11, 2'h3, 1'b0, 14'h0000, 14'h0000);
      i_dev.send_char(6'h07, 1'b1, 1'b0);
      chk("error", channel_error_test, 1'b1);
      ctl(6'h11, 2'h3, 1'b0, 14'h0000, 14'h0000);
      chk("error", channel_error_test, 1'b0);
   endtask : t_parity
   task t_eor;
      t = eots;
      e = eows;
      ctl(6'h12, 2'h3, 1'b0, 14'h0000, 14'h0000);
      i_dev.send_char(6'h01, 1'b0, 1'b0);
      i_dev.send_char(6'h3e, 1'b0, 1'b1);
      wait_cnt(1, t);
      chk("word", buf_to_mem_data, {6'h01, 6'h3e, 12'h000});
      chk("full", buffer_full_flag, 1'b1);
      chk("eow", 24'(eows - e), 24'h000000);
      chk("program", pirq, 1'b1);
      chk("address", unit_address_display, 6'h00);
      chk("ready", channel_ready_test, 1'b1);
      i_dev.clr_eor();
   endtask : t_eor
   task t_output;
      @(posedge sys_clk);
      irq_enable <= 1'b0;
      i_dev.out_q.delete();
      e = eows;
      t = eots;
      ctl(6'h21, 2'h1, 1'b0, 14'h0000, 14'h0000);
      wait_cnt(0, e);
      pulse(1, 24'h123456);
      chk("full", buffer_full_flag, 1'b1);
      wait_cnt(3, 1);
      chk("char0", i_dev.out_q[0], 6'h04);
      chk("char1", i_dev.out_q[1], 6'h23);
      wait_cnt(0, e + 1);
      pulse(1, 24'hfc1041);
      pulse(2, 24'h000000);
      wait_cnt(1, t);
      chk("char2", i_dev.out_q[2], 6'h3f);
      chk("char3", i_dev.out_q[3], 6'h01);
      chk("program", pirq, 1'b0);
      chk("ready", channel_ready_test, 1'b1);
      chk("parity", 24'(i_dev.bad_par), 24'h000000);
   endtask : t_output
   task t_il_out;
      i_dev.mem[5] = 24'ha80000;
      i_dev.mem[6] = 24'h540000;
      i_dev.out_q.delete();
      t = eots;
      ctl(6'h22, 2'h0, 1'b1, 14'h0002, 14'h0005);
      wait_cnt(1, t);
      chk("count", 24'(i_dev.out_q.size()), 24'h000002);
      chk("char0", i_dev.out_q[0], 6'h2a);
      chk("char1", i_dev.out_q[1], 6'h15);
      chk("ready", channel_ready_test, 1'b1);
   endtask : t_il_out
   task t_il_in;
      w = wrs;
      e = eows;
      ctl(6'h13, 2'h0, 1'b1, 14'h0001, 14'h0009);
      i_dev.send_char(6'h2d, 1'b0, 1'b0);
      wait_cnt(2, w);
      chk("memory", i_dev.mem[9], {18'h00000, 6'h2d});
      i_dev.send_char(6'h31, 1'b0, 1'b0);
      wait_cnt(0, e);
      chk("word", buf_to_mem_data, {18'h00000, 6'h31});
      chk("writes", 24'(wrs - w), 24'h000001);
      pulse(0, 24'h000000);
      t = eots;
      ctl(6'h14, 2'h0, 1'b1, 14'h0003, 14'h000c);
      i_dev.send_char(6'h0f, 1'b0, 1'b1);
      wait_cnt(1, t);
      chk("address", unit_address_display, 6'h00);
      i_dev.clr_eor();
   endtask : t_il_in

   initial begin
      srst = 1'b1;
      {ctl_strobe, ctl_interlace, buf_to_mem_strobe, mem_to_buf_strobe, terminate_strobe} = '0;
      {ctl_word, mem_to_buf_data, ctl_word_count, ctl_start_addr} = '0;
      irq_enable = 1'b1;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("ready", channel_ready_test, 1'b1);
      chk("address", unit_address_display, 6'h00);
      chk("flags", {channel_error_test, buffer_full_flag}, 2'h0);
      t_input;
      t_parity;
      t_eor;
      t_output;
      t_il_out;
      t_il_in;
      results;
   end
endmodule : tb_bic_channel
